// ---- design/rw_channel_ctrl.sv ----
// Purpose: Digital control of a disk read/write channel
// Assumes: All inputs synchronous to clk; osc_tick pulses once per double-rate cycle
// Notes: Analog head, crossover and driver electrics sit outside
`include "rw_chan_defines.svh"
module rw_channel_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Static configuration
  input wire logic high_rate,
  input wire logic mark_format,
  // Controller commands and data
  input wire logic head_select,
  input wire logic [`HEAD_ADDR_W-1:0] head_addr,
  input wire logic [`CYL_ADDR_W-1:0] cylinder_addr,
  input wire logic write_cmd,
  input wire logic read_cmd,
  input wire logic mark_command,
  input wire logic write_nrz,
  input wire logic strobe_early,
  input wire logic strobe_late,
  // Channel inputs
  input wire logic osc_tick,
  input wire logic servo_locked_pulses,
  input wire logic tri_frequency_code,
  input wire logic signal_loss,
  input wire logic recovered_nrz,
  // Controller outputs
  output logic rw_clock_q,
  output logic read_nrz_q,
  output logic mark_detected_q,
  // Head and write path
  output logic [`HEAD_COUNT-1:0] head_enable_n_q,
  output logic [`CUR_W-1:0] write_current_q,
  output logic write_receiver_en_q,
  output logic write_data_q,
  output rw_chan_pkg::comp_t write_timing_q,
  output logic write_gap_inhibit_q,
  // Read path and oscillator
  output logic read_driver_en_q,
  output logic crossover_enable_q,
  output logic miller_pulse_q,
  output logic [1:0] strobe_shift_q,
  output logic osc_ref_q,
  output logic osc_ref_read_q,
  output logic pd_phase_clock_q,
  output logic read_data_inhibit_q,
  output logic sync_enable_q
);
  logic [`HEAD_COUNT-1:0] head_dec;
  logic bit_tick;
  logic write_bit;
  logic rw_clock_d, read_nrz_d, mark_detected_d, tfm_q, tfm_d, miller_pulse_d;
  logic [`HEAD_COUNT-1:0] head_enable_n_d;
  logic [`CUR_W-1:0] write_current_d;
  logic write_receiver_en_d, write_gap_inhibit_d, gap_start_q, gap_start_d;
  logic read_driver_en_d, crossover_enable_d, osc_ref_d, osc_ref_read_d;
  logic pd_phase_clock_d, read_data_inhibit_d, sync_enable_d;
  logic [1:0] strobe_shift_d;
  logic [`CNT_W-1:0] gap_cnt_q, gap_cnt_d, cnt_q, cnt_d, lock_len;
  rw_chan_pkg::read_phase_t phase_q, phase_d;

  // One decoder line per head
  generate
    for (genvar i = 0; i < `HEAD_COUNT; i++)
    begin : g_head
      assign head_dec[i] = head_select && (head_addr == `HEAD_ADDR_W'(i));
    end
  endgenerate

  // Bit tick lands where the bit clock falls
  assign bit_tick = osc_tick && rw_clock_q;
  assign lock_len = high_rate ? `LOCK_BITS_HIGH : `LOCK_BITS_LOW;

  // Datapath and write gap
  always_comb
  begin
    rw_clock_d = osc_tick ? !rw_clock_q : rw_clock_q;
    head_enable_n_d = ~head_dec;
    write_current_d = ~cylinder_addr[`CUR_LSB +: `CUR_W];
    write_receiver_en_d = write_cmd;
    read_driver_en_d = read_cmd;
    osc_ref_read_d = read_cmd;
    osc_ref_d = read_cmd ? miller_pulse_q : servo_locked_pulses;
    tfm_d = tri_frequency_code;
    miller_pulse_d = tri_frequency_code ^ tfm_q;
    strobe_shift_d = read_cmd ? {strobe_early, strobe_late && !strobe_early} : 2'h0;
    gap_start_d = write_cmd && mark_command;
    gap_cnt_d = gap_cnt_q;
    write_gap_inhibit_d = write_gap_inhibit_q;
    if (gap_start_d && !gap_start_q)
    begin
      gap_cnt_d = `CNT_W'h0;
      write_gap_inhibit_d = 1'b1;
    end
    else if (write_gap_inhibit_q && bit_tick)
    begin
      gap_cnt_d = gap_cnt_q + `CNT_W'h1;
      if (gap_cnt_q == `GAP_BITS - `CNT_W'h1)
        write_gap_inhibit_d = 1'b0;
    end
    // Gap blocks data ahead of the compensator, so only the two bits already inside it drain out
    write_bit = write_receiver_en_q && !write_gap_inhibit_d && write_nrz;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rw_clock_q <= 1'b0;
      head_enable_n_q <= {`HEAD_COUNT{1'b1}};
      write_current_q <= {`CUR_W{1'b0}};
      write_receiver_en_q <= 1'b0;
      read_driver_en_q <= 1'b0;
      osc_ref_read_q <= 1'b0;
      osc_ref_q <= 1'b0;
      tfm_q <= 1'b0;
      miller_pulse_q <= 1'b0;
      strobe_shift_q <= 2'h0;
      gap_start_q <= 1'b0;
      gap_cnt_q <= `CNT_W'h0;
      write_gap_inhibit_q <= 1'b0;
    end
    else
    begin
      rw_clock_q <= rw_clock_d;
      head_enable_n_q <= head_enable_n_d;
      write_current_q <= write_current_d;
      write_receiver_en_q <= write_receiver_en_d;
      read_driver_en_q <= read_driver_en_d;
      osc_ref_read_q <= osc_ref_read_d;
      osc_ref_q <= osc_ref_d;
      tfm_q <= tfm_d;
      miller_pulse_q <= miller_pulse_d;
      strobe_shift_q <= strobe_shift_d;
      gap_start_q <= gap_start_d;
      gap_cnt_q <= gap_cnt_d;
      write_gap_inhibit_q <= write_gap_inhibit_d;
    end
  end

  write_precomp u_precomp (
    .clk(clk),
    .resetn(resetn),
    .bit_tick(bit_tick),
    .high_rate(high_rate),
    .data_in(write_bit),
    .data_out_q(write_data_q),
    .timing_q(write_timing_q)
  );

  // Read sequencer
  always_comb
  begin
    phase_d = phase_q;
    cnt_d = cnt_q;
    mark_detected_d = mark_detected_q && read_cmd;
    case (phase_q)
      rw_chan_pkg::RD_IDLE:
      begin
        cnt_d = `CNT_W'h0;
        if (read_cmd && !mark_format)
          phase_d = rw_chan_pkg::RD_LOCK;
        else if (read_cmd && mark_command)
          phase_d = rw_chan_pkg::RD_SEARCH;
      end
      rw_chan_pkg::RD_SEARCH:
      begin
        if (bit_tick)
        begin
          // Loss must persist, so a bad spot is not taken for a mark
          cnt_d = signal_loss ? cnt_q + `CNT_W'h1 : `CNT_W'h0;
          if (signal_loss && cnt_q == `MARK_VERIFY_BITS - `CNT_W'h1)
          begin
            cnt_d = `CNT_W'h0;
            mark_detected_d = 1'b1;
            phase_d = rw_chan_pkg::RD_LOCK;
          end
        end
      end
      rw_chan_pkg::RD_LOCK, rw_chan_pkg::RD_RELOCK:
      begin
        if (bit_tick)
        begin
          cnt_d = cnt_q + `CNT_W'h1;
          if (cnt_q == lock_len - `CNT_W'h1)
          begin
            cnt_d = `CNT_W'h0;
            phase_d = (phase_q == rw_chan_pkg::RD_LOCK) ? rw_chan_pkg::RD_ID : rw_chan_pkg::RD_DATA;
          end
        end
      end
      rw_chan_pkg::RD_ID:
      begin
        if (bit_tick)
        begin
          cnt_d = cnt_q + `CNT_W'h1;
          if (cnt_q == `ID_FIELD_BITS - `CNT_W'h1)
          begin
            cnt_d = `CNT_W'h0;
            phase_d = rw_chan_pkg::RD_RELOCK;
          end
        end
      end
      rw_chan_pkg::RD_DATA:
        cnt_d = `CNT_W'h0;
      default:
        phase_d = rw_chan_pkg::RD_IDLE;
    endcase
    if (!read_cmd)
      phase_d = rw_chan_pkg::RD_IDLE;
    pd_phase_clock_d = (phase_d == rw_chan_pkg::RD_LOCK) || (phase_d == rw_chan_pkg::RD_RELOCK);
    read_data_inhibit_d = pd_phase_clock_d;
    sync_enable_d = pd_phase_clock_d;
    crossover_enable_d = read_cmd && (phase_d != rw_chan_pkg::RD_SEARCH);
    read_nrz_d = read_nrz_q;
    if (!read_cmd || read_data_inhibit_d)
      read_nrz_d = 1'b0;
    else if (bit_tick)
      read_nrz_d = recovered_nrz;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      phase_q <= rw_chan_pkg::RD_IDLE;
      cnt_q <= `CNT_W'h0;
      mark_detected_q <= 1'b0;
      pd_phase_clock_q <= 1'b0;
      read_data_inhibit_q <= 1'b0;
      sync_enable_q <= 1'b0;
      crossover_enable_q <= 1'b0;
      read_nrz_q <= 1'b0;
    end
    else
    begin
      phase_q <= phase_d;
      cnt_q <= cnt_d;
      mark_detected_q <= mark_detected_d;
      pd_phase_clock_q <= pd_phase_clock_d;
      read_data_inhibit_q <= read_data_inhibit_d;
      sync_enable_q <= sync_enable_d;
      crossover_enable_q <= crossover_enable_d;
      read_nrz_q <= read_nrz_d;
    end
  end

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  a_head_one_hot: assert property (head_select && head_addr < `HEAD_ADDR_W'(`HEAD_COUNT) |=>
    $countones(~head_enable_n_q) == 1 && !head_enable_n_q[$past(head_addr)])
    else $error("head decode not one-hot");
  a_gap_length: assert property ($rose(write_gap_inhibit_q) |-> gap_cnt_q == `CNT_W'h0 ##1
    (gap_cnt_q <= `GAP_BITS) [*8])
    else $error("write gap count out of range");
  // Two older bits still drain from the compensator as the gap opens
  a_gap_blocks_data: assert property (write_gap_inhibit_q && gap_cnt_q >= `CNT_W'h3 |-> !write_data_q)
    else $error("write data leaked in gap");
  a_clock_divide: assert property (osc_tick |=> rw_clock_q != $past(rw_clock_q))
    else $error("bit clock did not toggle");
  a_read_edge: assert property ($rose(read_nrz_q) |-> $fell(rw_clock_q))
    else $error("read data moved off falling edge");
  a_lock_inhibit: assert property (sync_enable_q |-> read_data_inhibit_q && !read_nrz_q && pd_phase_clock_q)
    else $error("read data not inhibited in lock");
  a_lock_count: assert property (phase_q == rw_chan_pkg::RD_LOCK |-> cnt_q < lock_len)
    else $error("lock count overran");
  a_search_xover: assert property (phase_q == rw_chan_pkg::RD_SEARCH |-> !crossover_enable_q)
    else $error("crossover enabled in search");
  a_osc_ref: assert property (!read_cmd |=> !osc_ref_read_q && osc_ref_q == $past(servo_locked_pulses))
    else $error("servo reference not selected");
  a_miller_edge: assert property (1 |=> miller_pulse_q ==
    ($past(tri_frequency_code) != $past(tri_frequency_code, 2)))
    else $error("miller pulse wrong");
  a_current_step: assert property (1 |=> write_current_q == ~$past(cylinder_addr[`CUR_LSB +: `CUR_W]))
    else $error("write current level wrong");
  c_mark_gap: cover property ($fell(write_gap_inhibit_q));
  c_mark_found: cover property ($rose(mark_detected_q));
  c_record_read: cover property (phase_q == rw_chan_pkg::RD_DATA);
  c_precomp_early: cover property (write_timing_q == rw_chan_pkg::COMP_EARLY);
endmodule : rw_channel_ctrl

// ---- design/write_precomp.sv ----
// Purpose: Peak shift compensator for the write stream
// Assumes: bit_tick is one cycle per bit cell
// Notes: Bypassed, on time, in the lower-rate variant
`include "rw_chan_defines.svh"
module write_precomp (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control
  input wire logic bit_tick,
  input wire logic high_rate,
  // Stream
  input wire logic data_in,
  output logic data_out_q,
  output rw_chan_pkg::comp_t timing_q
);
  logic [2:0] shift_q;
  logic [2:0] shift_d;
  logic data_out_d;
  rw_chan_pkg::comp_t timing_d;

  always_comb
  begin
    shift_d = shift_q;
    data_out_d = data_out_q;
    timing_d = timing_q;
    if (bit_tick)
    begin
      // Serial shift; middle bit is judged by its neighbours
      shift_d = {shift_q[1:0], data_in};
      data_out_d = shift_q[1];
      timing_d = rw_chan_pkg::COMP_ON_TIME;
      if (high_rate && shift_q[1])
      begin
        if (shift_q[2] && !shift_q[0])
          timing_d = rw_chan_pkg::COMP_LATE;
        else if (!shift_q[2] && shift_q[0])
          timing_d = rw_chan_pkg::COMP_EARLY;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      shift_q <= 3'h0;
      data_out_q <= 1'b0;
      timing_q <= rw_chan_pkg::COMP_ON_TIME;
    end
    else
    begin
      shift_q <= shift_d;
      data_out_q <= data_out_d;
      timing_q <= timing_d;
    end
  end
endmodule : write_precomp

// ---- dv/ctrl_model.sv ----
// Purpose: Far-side model, controller write data and oscillator ticks
// Assumes: Oscillator ticks on every second clk
// Notes: Counts bit clock falls so the bench can measure spans
module ctrl_model (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Bit clock from the channel
  input wire logic rw_clock_q,
  // Toward the channel, plus the fall count for the bench
  output logic osc_tick = 1'b0,
  output logic servo_locked_pulses = 1'b0,
  output logic write_nrz = 1'b0,
  output int fall_cnt = 0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rw_prev_q = 1'b0;
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      osc_tick <= 1'b0;
      servo_locked_pulses <= 1'b0;
      rw_prev_q <= 1'b0;
    end
    else
    begin
      osc_tick <= !osc_tick;
      // Servo pulses ride on the oscillator so they stay in step
      servo_locked_pulses <= osc_tick;
      rw_prev_q <= rw_clock_q;
      // One cycle late, but spans are taken as differences
      if (rw_prev_q && !rw_clock_q)
      begin
        fall_cnt <= fall_cnt + 1;
        // Runs of two give the compensator both early and late cases
        write_nrz <= fall_cnt[1];
      end
    end
  end
endmodule : ctrl_model

// ---- dv/tb_top.sv ----
// Purpose: Self-checking bench for the read/write channel control block
// Assumes: ctrl_model supplies oscillator ticks and write data
// Notes: Spans are counted in bit clock falls with one tick of slack
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, resetn = 1'b0, high_rate = 1'b0, mark_format = 1'b0, head_select = 1'b0;
  logic write_cmd = 1'b0, read_cmd = 1'b0, mark_command = 1'b0, strobe_early = 1'b0, strobe_late = 1'b0;
  logic tri_frequency_code = 1'b0, signal_loss = 1'b0, recovered_nrz = 1'b0;
  logic [4:0] head_addr = 5'h00;
  logic [9:0] cylinder_addr = 10'h000;
  logic osc_tick, servo_locked_pulses, write_nrz, rw_clock_q, read_nrz_q, mark_detected_q;
  logic write_receiver_en_q, write_data_q, write_gap_inhibit_q, read_driver_en_q, crossover_enable_q;
  logic miller_pulse_q, osc_ref_q, osc_ref_read_q, pd_phase_clock_q, read_data_inhibit_q, sync_enable_q;
  logic [18:0] head_enable_n_q;
  logic [2:0] write_current_q;
  logic [1:0] strobe_shift_q;
  rw_chan_pkg::comp_t write_timing_q;
  int fall_cnt, err_total = 0, n_checks = 0;

  always #10 clk = ~clk;

  ctrl_model ctrl_model_inst (.clk(clk), .resetn(resetn), .rw_clock_q(rw_clock_q), .osc_tick(osc_tick),
    .servo_locked_pulses(servo_locked_pulses), .write_nrz(write_nrz), .fall_cnt(fall_cnt));

  rw_channel_ctrl rw_channel_ctrl_inst (.clk(clk), .resetn(resetn), .high_rate(high_rate),
    .mark_format(mark_format), .head_select(head_select), .head_addr(head_addr), .cylinder_addr(cylinder_addr),
    .write_cmd(write_cmd), .read_cmd(read_cmd), .mark_command(mark_command), .write_nrz(write_nrz),
    .strobe_early(strobe_early), .strobe_late(strobe_late), .osc_tick(osc_tick),
    .servo_locked_pulses(servo_locked_pulses), .tri_frequency_code(tri_frequency_code),
    .signal_loss(signal_loss), .recovered_nrz(recovered_nrz), .rw_clock_q(rw_clock_q),
    .read_nrz_q(read_nrz_q), .mark_detected_q(mark_detected_q), .head_enable_n_q(head_enable_n_q),
    .write_current_q(write_current_q), .write_receiver_en_q(write_receiver_en_q),
    .write_data_q(write_data_q), .write_timing_q(write_timing_q), .write_gap_inhibit_q(write_gap_inhibit_q),
    .read_driver_en_q(read_driver_en_q), .crossover_enable_q(crossover_enable_q),
    .miller_pulse_q(miller_pulse_q), .strobe_shift_q(strobe_shift_q), .osc_ref_q(osc_ref_q),
    .osc_ref_read_q(osc_ref_read_q), .pd_phase_clock_q(pd_phase_clock_q),
    .read_data_inhibit_q(read_data_inhibit_q), .sync_enable_q(sync_enable_q));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_near(input int got, input int exp);
    n_checks++;
    if (got < exp - 1 || got > exp + 1)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: span %0d bits, expected %0d", $time, got, exp);
    end
  endtask : chk_near

  function automatic logic pick(input int k);
    return k == 0 ? read_data_inhibit_q : k == 1 ? write_gap_inhibit_q : mark_detected_q;
  endfunction : pick

  task automatic wait_lvl(input int k, input logic v);
    int t;
    t = 0;
    while (pick(k) !== v && t < 1000)
    begin
      @(posedge clk);
      #1;
      t++;
    end
    if (pick(k) !== v)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: level wait timed out", $time);
    end
  endtask : wait_lvl

  task automatic hold_len(input int k, input logic v, input int exp);
    int n0;
    wait_lvl(k, v);
    n0 = fall_cnt;
    wait_lvl(k, !v);
    chk_near(fall_cnt - n0, exp);
  endtask : hold_len

  task automatic apply_reset(input logic hr, input logic mf);
    @(posedge clk);
    resetn <= 1'b0;
    high_rate <= hr;
    mark_format <= mf;
    {head_select, write_cmd, read_cmd, mark_command, signal_loss, tri_frequency_code} <= 6'h00;
    {strobe_early, strobe_late} <= 2'h0;
    repeat (12) @(posedge clk);
    #1;
    chk(head_enable_n_q, 32'h0007ffff);
    @(posedge clk);
    resetn <= 1'b1;
  endtask : apply_reset

  task automatic test_heads();
    logic [9:0] c;
    for (int a = 0; a < 32; a++)
    begin
      c = 10'(a * 37);
      @(posedge clk);
      head_select <= 1'b1;
      head_addr <= 5'(a);
      cylinder_addr <= c;
      @(posedge clk);
      #1;
      chk(head_enable_n_q, a < 19 ? 32'h0007ffff & ~(32'h1 << a) : 32'h0007ffff);
      chk(write_current_q, 32'h7 - c[9:7]);
    end
    @(posedge clk);
    head_select <= 1'b0;
    @(posedge clk);
    #1;
    chk(head_enable_n_q, 32'h0007ffff);
  endtask : test_heads

  task automatic test_write(input logic hr);
    logic s, se, sl, sd;
    int n0;
    apply_reset(hr, 1'b1);
    // Skip the divider start-up so the window sees steady falls
    repeat (4) @(posedge clk);
    #1;
    n0 = fall_cnt;
    repeat (80) @(posedge clk);
    #1;
    s = servo_locked_pulses;
    chk(32'(fall_cnt - n0), 32'h14);
    @(posedge clk);
    #1;
    chk(osc_ref_q, s);
    @(posedge clk);
    write_cmd <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({write_receiver_en_q, osc_ref_read_q, pd_phase_clock_q}, 3'h4);
    // Ten bit cells cover a full data period whatever its phase
    se = 1'b0;
    sl = 1'b0;
    sd = 1'b0;
    repeat (40)
    begin
      @(posedge clk);
      #1;
      se |= write_timing_q == rw_chan_pkg::COMP_EARLY;
      sl |= write_timing_q == rw_chan_pkg::COMP_LATE;
      sd |= write_data_q;
      if (!hr)
        chk(write_timing_q, rw_chan_pkg::COMP_ON_TIME);
    end
    chk({se, sl, sd}, {hr, hr, 1'b1});
    @(posedge clk);
    mark_command <= 1'b1;
    hold_len(1, 1'b1, 24);
    chk(write_data_q, 1'b0);
    @(posedge clk);
    {write_cmd, mark_command} <= 2'h0;
  endtask : test_write

  task automatic test_read_plain(input logic hr);
    int lk, m;
    logic pn, pr;
    lk = hr ? 48 : 26;
    m = 0;
    apply_reset(hr, 1'b0);
    @(posedge clk);
    read_cmd <= 1'b1;
    recovered_nrz <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({read_driver_en_q, osc_ref_read_q, crossover_enable_q}, 3'h7);
    chk({read_data_inhibit_q, sync_enable_q, pd_phase_clock_q, read_nrz_q}, 4'he);
    hold_len(0, 1'b1, lk);
    chk(pd_phase_clock_q, 1'b0);
    hold_len(0, 1'b0, 64);
    chk(pd_phase_clock_q, 1'b1);
    hold_len(0, 1'b1, lk);
    pn = read_nrz_q;
    pr = rw_clock_q;
    for (int i = 0; i < 24; i++)
    begin
      @(posedge clk);
      recovered_nrz <= i[2];
      tri_frequency_code <= i[2];
      #1;
      if (read_nrz_q !== pn)
        chk({pr, rw_clock_q}, 2'h2);
      if (miller_pulse_q === 1'b1)
        m++;
      pn = read_nrz_q;
      pr = rw_clock_q;
    end
    chk(m, 5);
    @(posedge clk);
    {strobe_early, strobe_late} <= 2'h3;
    repeat (2) @(posedge clk);
    #1;
    chk(strobe_shift_q, 2'h2);
    @(posedge clk);
    {read_cmd, strobe_early} <= 2'h0;
    repeat (2) @(posedge clk);
    #1;
    chk({read_driver_en_q, osc_ref_read_q, strobe_shift_q, read_nrz_q}, 5'h00);
  endtask : test_read_plain

  task automatic test_mark();
    int n0;
    apply_reset(1'b1, 1'b1);
    @(posedge clk);
    read_cmd <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    chk({read_data_inhibit_q, pd_phase_clock_q}, 2'h0);
    @(posedge clk);
    mark_command <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({crossover_enable_q, mark_detected_q, pd_phase_clock_q}, 3'h0);
    @(posedge clk);
    signal_loss <= 1'b1;
    n0 = fall_cnt;
    wait_lvl(2, 1'b1);
    chk_near(fall_cnt - n0, 16);
    n0 = fall_cnt;
    repeat (2) @(posedge clk);
    #1;
    chk({pd_phase_clock_q, read_data_inhibit_q, sync_enable_q, crossover_enable_q}, 4'hf);
    @(posedge clk);
    {signal_loss, mark_command} <= 2'h0;
    wait_lvl(0, 1'b0);
    chk_near(fall_cnt - n0, 48);
    @(posedge clk);
    read_cmd <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(mark_detected_q, 1'b0);
  endtask : test_mark

  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  initial
  begin
    apply_reset(1'b1, 1'b0);
    test_heads();
    test_write(1'b1);
    test_write(1'b0);
    test_read_plain(1'b1);
    test_read_plain(1'b0);
    test_mark();
    give_verdict();
  end

  // About five times the expected run
  initial
  begin
    #200000;
    err_total++;
    give_verdict();
  end
endmodule : tb_top

// ---- pkg/rw_chan_defines.svh ----
// Purpose: Constants for the read/write channel control block
// Assumes: Counts are in bit times unless named otherwise
// Notes: Included by the design files only
`ifndef RW_CHAN_DEFINES_SVH
`define RW_CHAN_DEFINES_SVH
`define HEAD_COUNT 19
`define HEAD_ADDR_W 5
`define CYL_ADDR_W 10
`define CUR_LSB 7
`define CUR_W 3
`define CNT_W 7
`define GAP_BITS 7'h18
`define LOCK_BITS_HIGH 7'h30
`define LOCK_BITS_LOW 7'h1a
`define ID_FIELD_BITS 7'h40
`define MARK_VERIFY_BITS 7'h10
`define BIT_RATE_HIGH_KHZ 9670
`define BIT_RATE_LOW_KHZ 6400
`endif

// ---- pkg/rw_chan_pkg.sv ----
// Purpose: Types shared by the read/write channel control files
// Assumes: Nothing beyond the defines header
// Notes: Enumerations carry no explicit codes
package rw_chan_pkg;
  typedef enum logic [2:0] {RD_IDLE, RD_SEARCH, RD_LOCK, RD_ID, RD_RELOCK, RD_DATA} read_phase_t;
  typedef enum logic [1:0] {COMP_ON_TIME, COMP_EARLY, COMP_LATE} comp_t;
endpackage : rw_chan_pkg
